// file: logic/tap_controller.v
`timescale 1ns/1ps
`include "tap_regs.vh"

module tap_controller #(
   parameter [3:0]  ID_REVISION = 4'h1,   // arbitrary value
   parameter [4:0]  ID_DEPTH    = 5'h09,  // arbitrary value
   parameter [4:0]  ID_WIDTH    = 5'h0A,  // arbitrary value
   parameter [5:0]  ID_DEVNUM   = 6'h00,  // arbitrary value
   parameter [10:0] ID_MAKER    = 11'h155 // arbitrary value
) (
   input  wire                    clock,
   input  wire                    rst,
   input  wire                    ce,
   input  wire                    tck,
   input  wire                    tms,
   input  wire                    tdi,
   input  wire [`TAP_BSR_LEN-1:0] ioRing,
   output reg                     tdo_q,
   output reg                     tdoOe_q,
   output reg                     memOutputsOff_q,
   output reg  [`TAP_IR_LEN-1:0]  instruction_q,
   output reg  [3:0]              tapState_q
);

   ////////////////////////////////////////////////////////////////////////
   // controller state codes
   localparam [3:0] ST_RESET      = 4'h0;
   localparam [3:0] ST_IDLE       = 4'h1;
   localparam [3:0] ST_SEL_DR     = 4'h2;
   localparam [3:0] ST_CAPTURE_DR = 4'h3;
   localparam [3:0] ST_SHIFT_DR   = 4'h4;
   localparam [3:0] ST_EXIT1_DR   = 4'h5;
   localparam [3:0] ST_PAUSE_DR   = 4'h6;
   localparam [3:0] ST_EXIT2_DR   = 4'h7;
   localparam [3:0] ST_UPDATE_DR  = 4'h8;
   localparam [3:0] ST_SEL_IR     = 4'h9;
   localparam [3:0] ST_CAPTURE_IR = 4'hA;
   localparam [3:0] ST_SHIFT_IR   = 4'hB;
   localparam [3:0] ST_EXIT1_IR   = 4'hC;
   localparam [3:0] ST_PAUSE_IR   = 4'hD;
   localparam [3:0] ST_EXIT2_IR   = 4'hE;
   localparam [3:0] ST_UPDATE_IR  = 4'hF;

   ////////////////////////////////////////////////////////////////////////
   // declarations
   wire                    tckSync;
   wire                    tmsSync;
   wire                    tdiSync;
   wire [`TAP_BSR_LEN-1:0] ringSync;
   reg                     tckPrev_q;
   wire                    tckRise;
   wire                    tckFall;
   reg  [3:0]              tapState_d;
   reg  [`TAP_IR_LEN-1:0]  irShift_q;
   wire [`TAP_ID_LEN-1:0]  idWord;
   wire                    selBoundary;
   wire                    selIdent;
   wire                    selBypass;
   wire                    bsrOut;
   wire                    idOut;
   wire                    bypOut;
   reg                     drOut;
   wire                    inCapDr;
   wire                    inShiftDr;
   wire                    isExtest;
   wire                    isIdent;
   wire                    isSampleZ;
   wire                    isSample;
   wire                    isBypass;
   wire                    isUnused;
   wire                    forceOff;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers for the test pins and the sampled pin ring
   pin_sync #(
      .WIDTH (3)
   ) u_tapPins (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .d     ({tck, tms, tdi}),
      .q     ({tckSync, tmsSync, tdiSync})
   );

   pin_sync #(
      .WIDTH (`TAP_BSR_LEN)
   ) u_ringPins (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .d     (ioRing),
      .q     (ringSync)
   );

   ////////////////////////////////////////////////////////////////////////
   // test clock edge detection on the filtered level
   // a test clock level held under two clocks may go unseen
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         tckPrev_q <= 1'b0;
      end else if (ce) begin
         tckPrev_q <= tckSync;
      end
   end

   assign tckRise = ce & tckSync & ~tckPrev_q;
   assign tckFall = ce & ~tckSync & tckPrev_q;

   ////////////////////////////////////////////////////////////////////////
   // sixteen-state controller next state
   always @* begin
      tapState_d = tapState_q;
      case (tapState_q)
         ST_RESET:      tapState_d = tmsSync ? ST_RESET : ST_IDLE;
         ST_IDLE:       tapState_d = tmsSync ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR:     tapState_d = tmsSync ? ST_SEL_IR : ST_CAPTURE_DR;
         ST_CAPTURE_DR: tapState_d = tmsSync ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR:   tapState_d = tmsSync ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR:   tapState_d = tmsSync ? ST_UPDATE_DR : ST_PAUSE_DR;
         ST_PAUSE_DR:   tapState_d = tmsSync ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR:   tapState_d = tmsSync ? ST_UPDATE_DR : ST_SHIFT_DR;
         ST_UPDATE_DR:  tapState_d = tmsSync ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR:     tapState_d = tmsSync ? ST_RESET : ST_CAPTURE_IR;
         ST_CAPTURE_IR: tapState_d = tmsSync ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR:   tapState_d = tmsSync ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR:   tapState_d = tmsSync ? ST_UPDATE_IR : ST_PAUSE_IR;
         ST_PAUSE_IR:   tapState_d = tmsSync ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR:   tapState_d = tmsSync ? ST_UPDATE_IR : ST_SHIFT_IR;
         ST_UPDATE_IR:  tapState_d = tmsSync ? ST_SEL_DR : ST_IDLE;
         default:       tapState_d = ST_RESET;
      endcase
   end

   // state advances on each filtered rising test clock edge
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         tapState_q <= ST_RESET;
      end else if (tckRise) begin
         tapState_q <= tapState_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction shift stage: capture fixed pattern, shift toward bit zero
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         irShift_q <= `TAP_IR_CAPTURE;
      end else if (tckRise) begin
         if (tapState_q == ST_CAPTURE_IR) begin
            irShift_q <= `TAP_IR_CAPTURE;
         end else if (tapState_q == ST_SHIFT_IR) begin
            irShift_q <= {tdiSync, irShift_q[`TAP_IR_LEN-1:1]};
         end
      end
   end

   // active instruction: identity code in reset, new code on update-IR fall
   // loading on the fall keeps the code steady across the following rise
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         instruction_q <= `TAP_IR_RESET;
      end else if (ce) begin
         if (tapState_q == ST_RESET) begin
            instruction_q <= `TAP_IR_RESET;
         end else if (tckFall && tapState_q == ST_UPDATE_IR) begin
            instruction_q <= irShift_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode of the active instruction, one flag per usable code
   assign isExtest  = (instruction_q == `TAP_OP_EXTEST);
   assign isIdent   = (instruction_q == `TAP_OP_IDCODE);
   assign isSampleZ = (instruction_q == `TAP_OP_SAMPLE_Z);
   assign isSample  = (instruction_q == `TAP_OP_SAMPLE);
   assign isBypass  = (instruction_q == `TAP_OP_BYPASS);

   // the unused codes match none of the flags above; they get the
   // one-bit path so a stray load never breaks the chain length
   assign isUnused  = ~(isExtest | isIdent | isSampleZ | isSample | isBypass);

   // only the two high-impedance codes release the memory output drivers
   assign forceOff  = isExtest | isSampleZ;

   ////////////////////////////////////////////////////////////////////////
   // data register selection from the decoded instruction
   assign selBoundary = isExtest | isSampleZ | isSample;
   assign selIdent    = isIdent;
   assign selBypass   = isBypass | isUnused;

   assign inCapDr   = tckRise && (tapState_q == ST_CAPTURE_DR);
   assign inShiftDr = tckRise && (tapState_q == ST_SHIFT_DR);

   // fixed identity word
   assign idWord[`TAP_ID_REV_MSB:`TAP_ID_REV_LSB]       = ID_REVISION;
   assign idWord[`TAP_ID_DEPTH_MSB:`TAP_ID_DEPTH_LSB]   = ID_DEPTH;
   assign idWord[`TAP_ID_WIDTH_MSB:`TAP_ID_WIDTH_LSB]   = ID_WIDTH;
   assign idWord[`TAP_ID_DEVNUM_MSB:`TAP_ID_DEVNUM_LSB] = ID_DEVNUM;
   assign idWord[`TAP_ID_MFR_MSB:`TAP_ID_MFR_LSB]       = ID_MAKER;
   assign idWord[`TAP_ID_PRESENT_BIT]                   = `TAP_ID_PRESENT_VAL;

   ////////////////////////////////////////////////////////////////////////
   // boundary chain: pin ring snapshot, top bit fed from data in
   scan_shift_reg #(
      .WIDTH (`TAP_BSR_LEN)
   ) u_boundary (
      .clock     (clock),
      .rst       (rst),
      .ce        (ce),
      .capture   (inCapDr & selBoundary),
      .shift     (inShiftDr & selBoundary),
      .load      (ringSync),
      .serialIn  (tdiSync),
      .serialOut (bsrOut)
   );

   // identity register
   scan_shift_reg #(
      .WIDTH (`TAP_ID_LEN)
   ) u_ident (
      .clock     (clock),
      .rst       (rst),
      .ce        (ce),
      .capture   (inCapDr & selIdent),
      .shift     (inShiftDr & selIdent),
      .load      (idWord),
      .serialIn  (tdiSync),
      .serialOut (idOut)
   );

   // single-bit bypass
   scan_shift_reg #(
      .WIDTH (`TAP_BYPASS_LEN)
   ) u_bypass (
      .clock     (clock),
      .rst       (rst),
      .ce        (ce),
      .capture   (inCapDr & selBypass),
      .shift     (inShiftDr & selBypass),
      .load      (`TAP_BYPASS_CAPTURE),
      .serialIn  (tdiSync),
      .serialOut (bypOut)
   );

   // serial output of the selected data register
   always @* begin
      if (selBoundary) begin
         drOut = bsrOut;
      end else if (selIdent) begin
         drOut = idOut;
      end else begin
         drOut = bypOut;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data out changes on falling test clock; driven only while shifting
   // the enable drops on the first fall outside the shift states
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         tdo_q   <= 1'b0;
         tdoOe_q <= 1'b0;
      end else if (tckFall) begin
         if (tapState_q == ST_SHIFT_IR) begin
            tdo_q   <= irShift_q[0];
            tdoOe_q <= 1'b1;
         end else if (tapState_q == ST_SHIFT_DR) begin
            tdo_q   <= drOut;
            tdoOe_q <= 1'b1;
         end else begin
            tdoOe_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // memory output disable follows the active instruction only;
   // update-DR has no effect on it nor on any pin
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         memOutputsOff_q <= 1'b0;
      end else if (ce) begin
         memOutputsOff_q <= forceOff;
      end
   end

endmodule // tap_controller

// file: include/tap_regs.vh
`ifndef TAP_REGS_VH
`define TAP_REGS_VH

// register lengths
`define TAP_IR_LEN          3
`define TAP_ID_LEN          32
`define TAP_BYPASS_LEN      1
`define TAP_BSR_LEN         75

// instruction codes
`define TAP_OP_EXTEST       3'h0
`define TAP_OP_IDCODE       3'h1
`define TAP_OP_SAMPLE_Z     3'h2
`define TAP_OP_RSVD_A       3'h3
`define TAP_OP_SAMPLE       3'h4
`define TAP_OP_RSVD_B       3'h5
`define TAP_OP_RSVD_C       3'h6
`define TAP_OP_BYPASS       3'h7

// instruction register reset and capture values
`define TAP_IR_RESET        `TAP_OP_IDCODE
`define TAP_IR_CAPTURE      3'h1

// identity word field positions
`define TAP_ID_REV_MSB      31
`define TAP_ID_REV_LSB      28
`define TAP_ID_DEPTH_MSB    27
`define TAP_ID_DEPTH_LSB    23
`define TAP_ID_WIDTH_MSB    22
`define TAP_ID_WIDTH_LSB    18
`define TAP_ID_DEVNUM_MSB   17
`define TAP_ID_DEVNUM_LSB   12
`define TAP_ID_MFR_MSB      11
`define TAP_ID_MFR_LSB      1
`define TAP_ID_PRESENT_BIT  0
`define TAP_ID_PRESENT_VAL  1'h1

// bypass capture value
`define TAP_BYPASS_CAPTURE  1'h0

// test clock timing
`define TAP_TCK_MIN_PERIOD_NS 100
`define TAP_SYS_PERIOD_NS     50
`define TAP_TCK_MIN_CYCLES    ((`TAP_TCK_MIN_PERIOD_NS + `TAP_SYS_PERIOD_NS - 1) / `TAP_SYS_PERIOD_NS)

`endif

// file: logic/pin_sync.v
`timescale 1ns/1ps
// three-stage synchroniser; output follows only once stages two and three agree
module pin_sync #(
   parameter WIDTH = 1
) (
   input  wire             clock,
   input  wire             rst,
   input  wire             ce,
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);
   reg [WIDTH-1:0] s1_q;
   reg [WIDTH-1:0] s2_q;
   reg [WIDTH-1:0] s3_q;
   integer i;

   // s1 feeds s2 only; agreement filter looks at s2 and s3
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         s1_q <= {WIDTH{1'b0}};
         s2_q <= {WIDTH{1'b0}};
         s3_q <= {WIDTH{1'b0}};
         q    <= {WIDTH{1'b0}};
      end else if (ce) begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
               q[i] <= s3_q[i];
            end
         end
      end
   end
endmodule // pin_sync

// file: logic/scan_shift_reg.v
`timescale 1ns/1ps
// capture/shift data register; serial in at the top bit, out at bit zero
module scan_shift_reg #(
   parameter WIDTH = 1
) (
   input  wire             clock,
   input  wire             rst,
   input  wire             ce,
   input  wire             capture,
   input  wire             shift,
   input  wire [WIDTH-1:0] load,
   input  wire             serialIn,
   output wire             serialOut
);
   reg [WIDTH-1:0] data_q;
   integer         i;

   // capture has priority; shift moves toward bit zero
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         data_q <= {WIDTH{1'b0}};
      end else if (ce) begin
         if (capture) begin
            data_q <= load;
         end else if (shift) begin
            // every bit moves one place toward zero; a one-bit register only takes the new bit
            for (i = 0; i < WIDTH - 1; i = i + 1) begin
               data_q[i] <= data_q[i+1];
            end
            data_q[WIDTH-1] <= serialIn;
         end
      end
   end

   assign serialOut = data_q[0];
endmodule // scan_shift_reg

// file: tb/tap_controller_properties.sv
`timescale 1ns/1ps
`include "tap_regs.vh"
// pin-level checks of the test access port
module tap_controller_properties (
   input wire logic                    clock,
   input wire logic                    rst,
   input wire logic                    ce,
   input wire logic                    tck,
   input wire logic                    tms,
   input wire logic                    tdi,
   input wire logic [`TAP_BSR_LEN-1:0] ioRing,
   input wire logic                    tdo_q,
   input wire logic                    tdoOe_q,
   input wire logic                    memOutputsOff_q,
   input wire logic [`TAP_IR_LEN-1:0]  instruction_q,
   input wire logic [3:0]              tapState_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   // instruction register and output disable
   chk_reset_instr: assert property (tapState_q == 4'h0 && ce |=> instruction_q == `TAP_OP_IDCODE)
      else $error("instruction not restored in reset state");
   chk_hiz_map: assert property (ce |=> memOutputsOff_q ==
      ($past(instruction_q) inside {`TAP_OP_EXTEST, `TAP_OP_SAMPLE_Z})) else $error("output disable wrong");
   chk_instr_update: assert property ($changed(instruction_q) |-> $past(tapState_q) inside {4'h0, 4'hF})
      else $error("instruction changed outside update");

   ////////////////////////////////////////////////////////////////////////////////
   // state machine and serial output timing
   chk_oe_shift: assert property ($rose(tdoOe_q) |-> tapState_q inside {4'h4, 4'hB})
      else $error("data out enabled outside shift");
   chk_oe_reset: assert property (tapState_q == 4'h0 |-> !tdoOe_q)
      else $error("data out enabled in reset state");
   chk_capture_next: assert property ($changed(tapState_q) && $past(tapState_q) == 4'h3
      |-> tapState_q inside {4'h4, 4'h5}) else $error("bad step after capture");
   chk_state_rise: assert property ($changed(tapState_q) |-> $past(tck, 3))
      else $error("state moved without test clock rise");
   chk_tdo_fall: assert property ($changed(tdo_q) |-> !$past(tck, 3))
      else $error("data out moved without test clock fall");
endmodule // tap_controller_properties

bind tap_controller tap_controller_properties i_tap_controller_properties (.clock(clock), .rst(rst), .ce(ce),
   .tck(tck), .tms(tms), .tdi(tdi), .ioRing(ioRing), .tdo_q(tdo_q), .tdoOe_q(tdoOe_q),
   .memOutputsOff_q(memOutputsOff_q), .instruction_q(instruction_q), .tapState_q(tapState_q));

// file: tb/jtag_master.sv
`timescale 1ns/1ps
// board-side scan controller; one test clock period is eight system clocks
module jtag_master (
   input  wire logic clock,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // test clock stands low between steps
   initial begin
      tck = 1'h0;
      tms = 1'h0;
      tdi = 1'h0;
   end

   // mode and data settle one clock ahead of the rise, data out read before the fall
   task automatic step(input logic tmsV, input logic tdiV, output logic tdoV);
      @(posedge clock);
      tms <= tmsV;
      tdi <= tdiV;
      @(posedge clock);
      tck <= 1'h1;
      repeat (4) @(posedge clock);
      tdoV = tdo;
      tck <= 1'h0;
      repeat (2) @(posedge clock);
   endtask

   // three-bit instruction shifted low bit first, from idle back to idle
   task automatic loadIr(input logic [2:0] code);
      logic b;
      step(1'h1, 1'h0, b);
      step(1'h1, 1'h0, b);
      step(1'h0, 1'h0, b);
      step(1'h0, 1'h0, b);
      for (int k = 0; k < 3; k++) step(k == 2, code[k], b);
      step(1'h1, 1'h0, b);
      step(1'h0, 1'h0, b);
   endtask
endmodule // jtag_master

// file: tb/tap_controller_test.sv
`timescale 1ns/1ps
`include "tap_regs.vh"
module tap_controller_test;
   localparam [31:0]  ID_EXP = {4'h1, 5'h09, 5'h0A, 6'h00, 11'h155, 1'h1};
   localparam [74:0]  RING   = {11'h4D3, 64'h0123456789ABCDEF};
   localparam [127:0] PAT    = {64'hF0E1D2C3B4A59687, 64'h1122334455667788};
   logic        clock;
   logic        rst;
   logic        ce;
   logic [74:0] ioRing;
   wire         tck;
   wire         tms;
   wire         tdi;
   wire         tdoPin;
   wire         tdo_q;
   wire         tdoOe_q;
   wire         memOutputsOff_q;
   wire [2:0]   instruction_q;
   wire [3:0]   tapState_q;
   int          errTotal;
   int          cmpCount;

   ////////////////////////////////////////////////////////////////////////////////
   // clock, design and scan controller
   always #25 clock = ~clock;
   tap_controller i_tap_controller (.clock(clock), .rst(rst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
      .ioRing(ioRing), .tdo_q(tdo_q), .tdoOe_q(tdoOe_q), .memOutputsOff_q(memOutputsOff_q),
      .instruction_q(instruction_q), .tapState_q(tapState_q));
   jtag_master i_jtag_master (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoPin));
   // released data out shows the inverse of its last level
   assign tdoPin = tdoOe_q ? tdo_q : ~tdo_q;

   ////////////////////////////////////////////////////////////////////////////////
   // compare, verdict and data scan
   task check(input string name, input logic [127:0] expV, input logic [127:0] gotV);
      cmpCount++;
      if (gotV !== expV) begin
         errTotal++;
         $display("mismatch %s expected %0h seen %0h", name, expV, gotV);
      end
   endtask

   task printVerdict;
      $display("checks %0d mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic scanDr(input int n, input logic [127:0] din, output logic [127:0] dout);
      logic b;
      dout = '0;
      i_jtag_master.step(1'h1, 1'h0, b);
      i_jtag_master.step(1'h0, 1'h0, b);
      i_jtag_master.step(1'h0, 1'h0, b);
      for (int k = 0; k < n; k++) begin
         i_jtag_master.step(k == n - 1, din[k], b);
         dout[k] = b;
      end
      i_jtag_master.step(1'h1, 1'h0, b);
      i_jtag_master.step(1'h0, 1'h0, b);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic testIdent;
      logic [127:0] d;
      scanDr(32, PAT, d);
      check("identity", ID_EXP, d[31:0]);
      check("outputs off", 1'h0, memOutputsOff_q);
   endtask

   task automatic testChain(input logic [2:0] code, input logic offExp);
      logic [127:0] d;
      i_jtag_master.loadIr(code);
      check("instruction", code, instruction_q);
      check("outputs off", offExp, memOutputsOff_q);
      scanDr(80, PAT, d);
      check("chain capture", RING, d[74:0]);
      check("chain length", PAT[4:0], d[79:75]);
      check("instruction after update", code, instruction_q);
      check("outputs after update", offExp, memOutputsOff_q);
   endtask

   task automatic testBypass;
      logic [127:0] d;
      i_jtag_master.loadIr(`TAP_OP_BYPASS);
      check("outputs off", 1'h0, memOutputsOff_q);
      scanDr(8, PAT, d);
      check("bypass stream", {PAT[6:0], 1'h0}, d[7:0]);
   endtask

   task automatic testLogicReset;
      logic b;
      i_jtag_master.loadIr(`TAP_OP_SAMPLE);
      repeat (5) i_jtag_master.step(1'h1, 1'h0, b);
      check("reset state", 4'h0, tapState_q);
      i_jtag_master.step(1'h0, 1'h0, b);
      check("instruction", `TAP_OP_IDCODE, instruction_q);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      logic b;
      clock = 1'h0;
      rst = 1'h1;
      ce = 1'h1;
      ioRing = RING;
      errTotal = 0;
      cmpCount = 0;
      repeat (10) @(posedge clock);
      rst <= 1'h0;
      repeat (4) @(posedge clock);
      check("instruction", `TAP_OP_IDCODE, instruction_q);
      check("data out enable", 1'h0, tdoOe_q);
      i_jtag_master.step(1'h0, 1'h0, b);
      testIdent();
      testChain(`TAP_OP_EXTEST, 1'h1);
      testChain(`TAP_OP_SAMPLE, 1'h0);
      testChain(`TAP_OP_SAMPLE_Z, 1'h1);
      testBypass();
      testLogicReset();
      testIdent();
      printVerdict();
   end

   initial begin
      #1000000;
      errTotal++;
      printVerdict();
   end
endmodule // tap_controller_test
